// ===== i2c_switch_pkg.sv
`default_nettype none
package i2c_switch_pkg;
  // control byte layout
  localparam int CHAN0_BIT = 0;
  localparam int CHAN1_BIT = 1;
  localparam int IRQ0_BIT = 4;
  localparam int IRQ1_BIT = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] CHAN_RESET = 2'h0;
  localparam logic RW_READ = 1'b1;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [5:0] SYNC_RESET = 6'h3F;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int MIN_QUARTER = 4;
  localparam int QCNT_W = 16;
  // host command port map
  localparam logic [2:0] HOST_TARGET = 3'h0;
  localparam logic [2:0] HOST_TXDATA = 3'h1;
  localparam logic [2:0] HOST_CMD = 3'h2;
  localparam logic [2:0] HOST_STATUS = 3'h3;
  localparam logic [2:0] HOST_RXDATA = 3'h4;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_IRQ_BIT = 2;
  localparam logic [7:0] BYTE_IDLE = 8'hFF;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_ADDR = 3'b001,
    D_ADDR_ACK = 3'b011,
    D_WRITE = 3'b010,
    D_WRITE_ACK = 3'b110,
    D_READ = 3'b111,
    D_READ_ACK = 3'b101
  } devState_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_XFER = 2'b11,
    H_STOP = 2'b10
  } hostState_t;
endpackage
`default_nettype wire

// ===== i2c_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface i2c_link_if;
  logic sclHostOe;
  logic sdaHostOe;
  logic sdaDevOe;
  logic irqOe;
  logic scl;
  logic sda;
  logic irqLine;
  // open-drain wires with pull-ups: low while any party drives
  assign scl = ~sclHostOe;
  assign sda = ~(sdaHostOe | sdaDevOe);
  assign irqLine = ~irqOe;
  modport host (output sclHostOe, output sdaHostOe,
                input sda, input irqLine);
  modport dev (output sdaDevOe, output irqOe, input scl, input sda);
endinterface
`default_nettype wire

// ===== switch_ctrl_host.sv
`timescale 1ns/10ps
`default_nettype none
module switch_ctrl_host
  import i2c_switch_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYCLES
)(
  input wire logic clk,
  input wire logic rst_n,
  i2c_link_if.host link,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWe,
  input wire logic regRe,
  output logic [7:0] regRdata
);
  if (QUARTER < MIN_QUARTER || QUARTER >= (1 << QCNT_W))
  begin : gBadQuarter
    $error("QUARTER out of range");
  end

  localparam logic [QCNT_W-1:0] QLAST = QCNT_W'(QUARTER - 1);

  hostState_t state_q, state_d;
  logic [QCNT_W-1:0] qCnt_q, qCnt_d;
  logic [1:0] phase_q, phase_d;
  logic [3:0] bitIdx_q, bitIdx_d;
  logic byteIdx_q, byteIdx_d;
  logic [7:0] shift_q, shift_d;
  logic [6:0] target_q, target_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] rx_q, rx_d;
  logic isRead_q, isRead_d;
  logic nack_q, nack_d;
  logic sclOe_q, sclOe_d;
  logic sdaOe_q, sdaOe_d;
  logic [7:0] rdata_d;
  logic [1:0] syncA_q;
  logic [1:0] syncB_q;
  logic sdaS;
  logic irqS;
  logic tick;
  logic recv;

  assign sdaS = syncB_q[0];
  assign irqS = syncB_q[1];
  assign tick = (qCnt_q == QLAST);
  assign recv = byteIdx_q & isRead_q;
  assign link.sclHostOe = sclOe_q;
  assign link.sdaHostOe = sdaOe_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA_q <= 2'h3;
      syncB_q <= 2'h3;
    end
    else
    begin
      syncA_q <= {link.irqLine, link.sda};
      syncB_q <= syncA_q;
    end
  end

  always_comb
  begin
    state_d = state_q;
    qCnt_d = '0;
    phase_d = phase_q;
    bitIdx_d = bitIdx_q;
    byteIdx_d = byteIdx_q;
    shift_d = shift_q;
    target_d = target_q;
    tx_d = tx_q;
    rx_d = rx_q;
    isRead_d = isRead_q;
    nack_d = nack_q;
    sclOe_d = sclOe_q;
    sdaOe_d = sdaOe_q;
    if (state_q != H_IDLE)
      qCnt_d = tick ? '0 : qCnt_q + 1'b1;
    if (tick)
      phase_d = phase_q + 1'b1;
    unique case (state_q)
      H_IDLE:
      begin
        phase_d = '0;
        if (regWe && regAddr == HOST_TARGET)
          target_d = regWdata[6:0];
        if (regWe && regAddr == HOST_TXDATA)
          tx_d = regWdata;
        if (regWe && regAddr == HOST_CMD && regWdata[CMD_GO_BIT])
        begin
          isRead_d = regWdata[CMD_READ_BIT];
          shift_d = {target_q, regWdata[CMD_READ_BIT]};
          nack_d = 1'b0;
          sdaOe_d = 1'b1;
          state_d = H_START;
        end
      end
      H_START:
        if (tick && phase_q == 2'h1)
        begin
          sclOe_d = 1'b1;
          phase_d = '0;
          bitIdx_d = '0;
          byteIdx_d = 1'b0;
          state_d = H_XFER;
        end
      H_XFER:
        if (tick)
          unique case (phase_q)
            2'h0:
              sdaOe_d = (bitIdx_q != ACK_SLOT) && !recv && !shift_q[7];
            2'h1:
              sclOe_d = 1'b0;
            2'h2:
              ;
            2'h3:
            begin
              sclOe_d = 1'b1;
              if (bitIdx_q != ACK_SLOT)
              begin
                shift_d = {shift_q[6:0], sdaS};
                bitIdx_d = bitIdx_q + 1'b1;
              end
              else if (byteIdx_q || sdaS)
              begin
                // stop right after the acknowledge slot of the last byte, or after a refused address
                nack_d = ~byteIdx_q & sdaS;
                if (recv)
                  rx_d = shift_q;
                state_d = H_STOP;
              end
              else
              begin
                byteIdx_d = 1'b1;
                bitIdx_d = '0;
                shift_d = isRead_q ? BYTE_IDLE : tx_q;
              end
            end
          endcase
      H_STOP:
        if (tick)
          unique case (phase_q)
            2'h0: sdaOe_d = 1'b1;
            2'h1: sclOe_d = 1'b0;
            2'h2: sdaOe_d = 1'b0;
            2'h3: state_d = H_IDLE;
          endcase
    endcase
  end

  always_comb
  begin
    rdata_d = '0;
    if (regRe)
      unique case (regAddr)
        HOST_TARGET: rdata_d = {1'b0, target_q};
        HOST_TXDATA: rdata_d = tx_q;
        HOST_RXDATA: rdata_d = rx_q;
        HOST_STATUS:
        begin
          rdata_d[STAT_BUSY_BIT] = (state_q != H_IDLE);
          rdata_d[STAT_NACK_BIT] = nack_q;
          rdata_d[STAT_IRQ_BIT] = ~irqS;
        end
        default: rdata_d = '0;
      endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= H_IDLE;
      qCnt_q <= '0;
      phase_q <= '0;
      bitIdx_q <= '0;
      byteIdx_q <= 1'b0;
      shift_q <= '0;
      target_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      isRead_q <= 1'b0;
      nack_q <= 1'b0;
      sclOe_q <= 1'b0;
      sdaOe_q <= 1'b0;
      regRdata <= '0;
    end
    else
    begin
      state_q <= state_d;
      qCnt_q <= qCnt_d;
      phase_q <= phase_d;
      bitIdx_q <= bitIdx_d;
      byteIdx_q <= byteIdx_d;
      shift_q <= shift_d;
      target_q <= target_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      isRead_q <= isRead_d;
      nack_q <= nack_d;
      sclOe_q <= sclOe_d;
      sdaOe_q <= sdaOe_d;
      regRdata <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// ===== switch_ctrl_dev.sv
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module switch_ctrl_dev
  import i2c_switch_pkg::*;
#(
  parameter logic [4:0] FIXED_ADDR_HI = 5'h15 // arbitrary value
)(
  input wire logic clk,
  input wire logic rst_n,
  i2c_link_if.dev link,
  input wire logic addrSelLo,
  input wire logic addrSelHi,
  input wire logic chan0IrqInN,
  input wire logic chan1IrqInN,
  output logic chan0Enable,
  output logic chan1Enable
);
  devState_t state_q, state_d;
  logic [5:0] syncA_q;
  logic [5:0] syncB_q;
  logic sclPrev_q;
  logic sdaPrev_q;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [7:0] shift_q, shift_d;
  logic isRead_q, isRead_d;
  logic masterAck_q, masterAck_d;
  logic [1:0] pend_q, pend_d;
  logic pendValid_q, pendValid_d;
  logic [1:0] chanEn_q, chanEn_d;
  logic sdaOe_q, sdaOe_d;
  logic irqOe_q, irqOe_d;
  logic sclS;
  logic sdaS;
  logic addrLoS;
  logic addrHiS;
  logic irq0S;
  logic irq1S;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic addrMatch;
  logic [7:0] txByte;

  assign {sclS, sdaS, addrHiS, addrLoS, irq1S, irq0S} = syncB_q;
  assign sclRise = sclS & ~sclPrev_q;
  assign sclFall = ~sclS & sclPrev_q;
  assign startCond = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
  assign stopCond = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
  assign addrMatch =
    (shift_q[7:1] == {FIXED_ADDR_HI, addrHiS, addrLoS});

  assign link.sdaDevOe = sdaOe_q;
  assign link.irqOe = irqOe_q;
  assign chan0Enable = chanEn_q[CHAN0_BIT];
  assign chan1Enable = chanEn_q[CHAN1_BIT];

  // every pin passes two flops; edges come from the second stage only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA_q <= SYNC_RESET;
      syncB_q <= SYNC_RESET;
    end
    else
    begin
      syncA_q <= {link.scl, link.sda, addrSelHi, addrSelLo,
                  chan1IrqInN, chan0IrqInN};
      syncB_q <= syncA_q;
    end
  end

  // read image: live irq levels, active selection, zeros elsewhere
  always_comb
  begin
    txByte = CTRL_RESET;
    txByte[CHAN0_BIT] = chanEn_q[CHAN0_BIT];
    txByte[CHAN1_BIT] = chanEn_q[CHAN1_BIT];
    txByte[IRQ0_BIT] = ~irq0S;
    txByte[IRQ1_BIT] = ~irq1S;
  end

  always_comb
  begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    shift_d = shift_q;
    isRead_d = isRead_q;
    masterAck_d = masterAck_q;
    pend_d = pend_q;
    pendValid_d = pendValid_q;
    chanEn_d = chanEn_q;
    sdaOe_d = sdaOe_q;
    // not gated by the selection, so a closed channel still flags
    irqOe_d = ~irq0S | ~irq1S;
    if (stopCond)
    begin
      state_d = D_IDLE;
      sdaOe_d = 1'b0;
      // lines are all high here, so switching now cannot glitch
      if (pendValid_q)
        chanEn_d = pend_q;
      pendValid_d = 1'b0;
    end
    else if (startCond)
    begin
      state_d = D_ADDR;
      bitCnt_d = '0;
      sdaOe_d = 1'b0;
    end
    else
      unique case (state_q)
        D_IDLE:
          ;
        D_ADDR, D_WRITE:
          if (sclRise)
          begin
            shift_d = {shift_q[6:0], sdaS};
            bitCnt_d = bitCnt_q + 1'b1;
          end
          else if (sclFall && bitCnt_q == BYTE_BITS)
          begin
            bitCnt_d = '0;
            if (state_q == D_WRITE)
            begin
              // a later byte simply overwrites the pending one
              pend_d = {shift_q[CHAN1_BIT],
                        shift_q[CHAN0_BIT]};
              pendValid_d = 1'b1;
              sdaOe_d = 1'b1;
              state_d = D_WRITE_ACK;
            end
            else if (addrMatch)
            begin
              isRead_d = (shift_q[0] == RW_READ);
              sdaOe_d = 1'b1;
              state_d = D_ADDR_ACK;
            end
            else
              state_d = D_IDLE;
          end
        D_ADDR_ACK:
          if (sclFall)
          begin
            bitCnt_d = '0;
            if (isRead_q)
            begin
              shift_d = txByte;
              sdaOe_d = ~txByte[7];
              state_d = D_READ;
            end
            else
            begin
              sdaOe_d = 1'b0;
              state_d = D_WRITE;
            end
          end
        D_WRITE_ACK:
          if (sclFall)
          begin
            sdaOe_d = 1'b0;
            state_d = D_WRITE;
          end
        D_READ:
          if (sclFall)
          begin
            if (bitCnt_q == LAST_DATA_BIT)
            begin
              bitCnt_d = '0;
              sdaOe_d = 1'b0;
              state_d = D_READ_ACK;
            end
            else
            begin
              bitCnt_d = bitCnt_q + 1'b1;
              shift_d = {shift_q[6:0], 1'b0};
              sdaOe_d = ~shift_q[6];
            end
          end
        D_READ_ACK:
          if (sclRise)
            masterAck_d = ~sdaS;
          else if (sclFall)
          begin
            if (masterAck_q)
            begin
              // fresh capture for each further byte of the read
              shift_d = txByte;
              sdaOe_d = ~txByte[7];
              state_d = D_READ;
            end
            else
              state_d = D_IDLE;
          end
        default:
        begin
          sdaOe_d = 1'b0;
          state_d = D_IDLE;
        end
      endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= D_IDLE;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      bitCnt_q <= '0;
      shift_q <= '0;
      isRead_q <= 1'b0;
      masterAck_q <= 1'b0;
      pend_q <= CHAN_RESET;
      pendValid_q <= 1'b0;
      chanEn_q <= CHAN_RESET;
      sdaOe_q <= 1'b0;
      irqOe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
      bitCnt_q <= bitCnt_d;
      shift_q <= shift_d;
      isRead_q <= isRead_d;
      masterAck_q <= masterAck_d;
      pend_q <= pend_d;
      pendValid_q <= pendValid_d;
      chanEn_q <= chanEn_d;
      sdaOe_q <= sdaOe_d;
      irqOe_q <= irqOe_d;
    end
  end
endmodule
`default_nettype wire

// ===== switch_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
module switch_ctrl_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sdaDevOe,
  input wire logic irqOe,
  input wire logic chan0IrqInN,
  input wire logic chan1IrqInN,
  input wire logic chan0Enable,
  input wire logic chan1Enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic sdaPrev_q;
  logic [3:0] sinceStop_q;
  logic [3:0] sinceStop_d;

  // saturating age of the last stop seen raw on the wires
  always_comb
  begin
    sinceStop_d = sinceStop_q;
    if (scl && sda && !sdaPrev_q)
      sinceStop_d = 4'h0;
    else if (sinceStop_q != 4'hF)
      sinceStop_d = sinceStop_q + 4'h1;
  end

  // prev starts high so a release of reset never looks like a stop
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sdaPrev_q <= 1'h1;
      sinceStop_q <= 4'hF;
    end
    else
    begin
      sdaPrev_q <= sda;
      sinceStop_q <= sinceStop_d;
    end
  end

  property p_chan_after_stop;
    ($changed(chan0Enable) || $changed(chan1Enable)) |-> sinceStop_q < 4'hC;
  endproperty
  a_chan_after_stop: assert property (p_chan_after_stop)
    else $error("channel selection moved with no recent stop");

  property p_chan_lines_high;
    ($changed(chan0Enable) || $changed(chan1Enable)) |-> scl && sda;
  endproperty
  a_chan_lines_high: assert property (p_chan_lines_high)
    else $error("channel selection moved while a line was low");

  property p_sda_low_phase;
    $changed(sdaDevOe) |-> !scl;
  endproperty
  a_sda_low_phase: assert property (p_sda_low_phase)
    else $error("device moved the data line while the clock was high");

  property p_release;
    $rose(rst_n) |-> !chan0Enable && !chan1Enable && !sdaDevOe && !irqOe;
  endproperty
  a_release: assert property (p_release)
    else $error("outputs not at defaults after reset");

  property p_irq_low;
    (!chan0IrqInN || !chan1IrqInN) [*6] |-> irqOe;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("irq output not pulled low for a low input");

  property p_irq_high;
    (chan0IrqInN && chan1IrqInN) [*6] |-> !irqOe;
  endproperty
  a_irq_high: assert property (p_irq_high)
    else $error("irq output low with both inputs high");

  property p_irq_rise;
    $rose(irqOe) |-> $past(!chan0IrqInN || !chan1IrqInN, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("irq output asserted without a low input");

  property p_irq_fall;
    $fell(irqOe) |-> $past(chan0IrqInN && chan1IrqInN, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq output released while an input was low");

  c_both: cover property (chan0Enable && chan1Enable);
  c_irq: cover property ($rose(irqOe));
  c_dev_drive: cover property ($rose(sdaDevOe));
endmodule
`default_nettype wire

// ===== i2c_two_channel_switch_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_two_channel_switch_control_tb_top
  import i2c_switch_pkg::*;
;
  localparam logic [4:0] ADDR_HI = 5'h15; // arbitrary value
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWe = 1'h0;
  logic regRe = 1'h0;
  logic [7:0] regRdata;
  logic selLo = 1'h0;
  logic selHi = 1'h0;
  logic irq0N = 1'h1;
  logic irq1N = 1'h1;
  logic ch0En;
  logic ch1En;
  logic [31:0] rnd = 32'h000166E6;
  logic [8:0] noteQ[$];
  logic rePend = 1'h0;
  int nFail = 0;
  int testsRun = 0;
  int cyc = 0;

  initial
  begin
    forever #50 clk = ~clk;
  end

  i2c_link_if link ();
  switch_ctrl_host #(.QUARTER(4)) switch_ctrl_host_inst (
    .clk(clk), .rst_n(rst_n), .link(link), .regAddr(regAddr),
    .regWdata(regWdata), .regWe(regWe), .regRe(regRe),
    .regRdata(regRdata));
  switch_ctrl_dev #(.FIXED_ADDR_HI(ADDR_HI)) switch_ctrl_dev_inst (
    .clk(clk), .rst_n(rst_n), .link(link), .addrSelLo(selLo),
    .addrSelHi(selHi), .chan0IrqInN(irq0N), .chan1IrqInN(irq1N),
    .chan0Enable(ch0En), .chan1Enable(ch1En));
  switch_ctrl_properties switch_ctrl_properties_inst (
    .clk(clk), .rst_n(rst_n), .scl(link.scl), .sda(link.sda),
    .sdaDevOe(link.sdaDevOe), .irqOe(link.irqOe),
    .chan0IrqInN(irq0N), .chan1IrqInN(irq1N),
    .chan0Enable(ch0En), .chan1Enable(ch1En));

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic void cmp(logic [7:0] got, logic [7:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      nFail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endfunction

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // read data stands only in the cycle after the strobe; judged
  // mid-cycle so the edge that clears it cannot race the sample
  always @(negedge clk)
  begin
    if (rePend && noteQ.size() > 0)
    begin
      if (noteQ[0][8])
        cmp(regRdata, noteQ[0][7:0]);
      void'(noteQ.pop_front());
    end
    rePend = regRe;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      nFail++;
      conclude();
    end
  end

  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWe <= 1'h1;
    @(posedge clk);
    regWe <= 1'h0;
  endtask

  // chk low marks a poll whose value the monitor must not judge
  task automatic rd(logic [2:0] a, logic chk, logic [7:0] e,
                    output logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regRe <= 1'h1;
    noteQ.push_back({chk, e});
    @(posedge clk);
    regRe <= 1'h0;
    @(negedge clk);
    v = regRdata;
    @(posedge clk);
  endtask

  task automatic xfer(logic [6:0] t, logic rw, logic [7:0] d);
    logic [7:0] s;
    int n;
    wr(HOST_TARGET, {1'h0, t});
    wr(HOST_TXDATA, d);
    wr(HOST_CMD, {6'h00, rw, 1'h1});
    repeat (2) @(posedge clk);
    s = 8'h01;
    n = 0;
    while (s[STAT_BUSY_BIT] !== 1'h0 && n < 2000)
    begin
      rd(HOST_STATUS, 1'h0, 8'h00, s);
      n++;
    end
    if (n == 2000)
      nFail++;
  endtask

  initial
  begin
    logic [7:0] d;
    logic [7:0] v;
    logic [7:0] ex;
    logic [6:0] a;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    a = {ADDR_HI, 2'h0};
    xfer(a, 1'h1, 8'h00);
    rd(HOST_RXDATA, 1'h1, 8'h00, v);
    rd(3'h7, 1'h1, 8'h00, v);
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      d = (i < 4) ? {rnd[7:2], i[1:0]} : rnd[7:0];
      a = {ADDR_HI, rnd[9], rnd[8]};
      selLo <= rnd[8];
      selHi <= rnd[9];
      irq0N <= ~i[1];
      irq1N <= ~(i[0] ^ i[2]);
      xfer(a, 1'h0, d);
      repeat (8) @(posedge clk);
      cmp({6'h00, ch1En, ch0En}, {6'h00, d[1:0]});
      cmp({7'h00, link.irqLine}, {7'h00, irq0N & irq1N});
      ex = {2'h0, ~irq1N, ~irq0N, 2'h0, d[1:0]};
      xfer(a, 1'h1, 8'h00);
      rd(HOST_RXDATA, 1'h1, ex, v);
    end
    // wrong select level: no acknowledge, selection untouched
    xfer({ADDR_HI, ~selHi, selLo}, 1'h0, 8'h00);
    rd(HOST_STATUS, 1'h1, {5'h00, ~(irq0N & irq1N), 2'h2}, v);
    cmp({6'h00, ch1En, ch0En}, {6'h00, d[1:0]});
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    cmp({6'h00, ch1En, ch0En}, 8'h00);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    xfer({ADDR_HI, selHi, selLo}, 1'h1, 8'h00);
    rd(HOST_RXDATA, 1'h1, {2'h0, ~irq1N, ~irq0N, 4'h0}, v);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule
`default_nettype wire
